// ===== mpc_regs.vh
// Register map, field positions and reset values of the motor protection block
`ifndef MPC_REGS_VH
`define MPC_REGS_VH
// ----------------------------------------
// Offsets
// ----------------------------------------
`define MPC_OFS_ENABLE   8'h00
`define MPC_OFS_POLICY   8'h04
`define MPC_OFS_STATUS   8'h08
`define MPC_OFS_MASK     8'h0C
`define MPC_OFS_STATE    8'h10
`define MPC_OFS_CMPVAL   8'h14
`define MPC_OFS_FLAGS    8'h18
`define MPC_OFS_CAPTURE  8'h1C
// ----------------------------------------
// Enable register fields
// ----------------------------------------
`define MPC_EN_CL        2
`define MPC_EN_OC        3
`define MPC_EN_CMP       4
`define MPC_EN_OVF       5
`define MPC_EN_SWE       6
`define MPC_EN_SWD       7
`define MPC_EN_MASK      8'hFC
// ----------------------------------------
// Policy register fields
// ----------------------------------------
`define MPC_POL_OVF      0
`define MPC_POL_CMP      1
`define MPC_POL_OC       2
`define MPC_POL_CL       3
`define MPC_POL_SW       4
`define MPC_POL_MASK     8'h1F
// ----------------------------------------
// Reset values and brake pattern
// ----------------------------------------
`define MPC_RST_ENABLE   8'h00
`define MPC_RST_POLICY   8'h13
`define MPC_RST_CMPVAL   16'h8000
`define MPC_BRAKE_PAT    6'h15
`endif

// ===== mpc_top.v
// Motor protection controller with APB register access and stall capture timer
//
// Design decisions made here: the APB slave port and the placing of the registers.
`timescale 1ns/1ns
`include "mpc_regs.vh"

// Function
// - Protect drives brake or all-off pattern
// - Fault policy follows source, releases automatically
// - Pause policy latches until software release
// - Bit 2 enables current-limit trigger
// - Current-limit resume immediate or next period
// - Bit 3 enables overcurrent, software restart only
// - Capture timer raises compare, overflow stall events
// - Bits 4,5 enable compare and overflow triggers
// - Overflow stall policy one selects pause
// - Software enable and data trigger protection
// - Software trigger policy zero fault, one pause
// - Enable bits 1,0 read zero, ignore writes
module mpc_top #(
   parameter TIMER_W = 16
) (
   // Clock and reset
   input  wire         mclk,
   input  wire         rst_n,
   // APB slave
   input  wire         psel,
   input  wire         penable,
   input  wire         pwrite,
   input  wire [7:0]   paddr,
   input  wire [31:0]  pwdata,
   output reg  [31:0]  prdata,
   output reg          pready,
   output reg          pslverr,
   // Trigger sources
   input  wire         current_limit_event,
   input  wire         overcurrent_event,
   input  wire         hall_input_a,
   input  wire         hall_input_b,
   input  wire         hall_input_c,
   input  wire         pwm_period_start,
   // Gate drive {AT,AB,BT,BB,CT,CB}
   input  wire [5:0]   pwm_gate_in,
   output reg  [5:0]   gate_out,
   output reg          protect_active,
   // Interrupt
   output reg          irq
);

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   reg [7:0]          protection_enable_control;
   reg [7:0]          protection_policy_select;
   reg [4:0]          status;
   reg [4:0]          mask;
   reg                free_run_select;
   reg [TIMER_W-1:0]  capture_compare;
   reg [TIMER_W-1:0]  capture_timer;
   reg [TIMER_W-1:0]  capture_latch;
   reg [2:0]          hall_prev;
   reg                hall_valid;
   reg                stall_compare_event;
   reg                stall_overflow_event;
   reg                cl_hold;
   reg                oc_latch;
   reg                cmp_latch;
   reg                ovf_latch;
   reg                sw_latch;

   // ----------------------------------------
   // Bus decode
   // ----------------------------------------
   wire        wr_done = psel & penable & pready & pwrite;
   // Access seen without ready is answered at the next edge: one wait state
   wire        acc     = psel & penable & ~pready;
   wire [31:0] wd      = pwdata;
   wire        wr_en   = wr_done & (paddr == `MPC_OFS_ENABLE);
   wire        wr_pol  = wr_done & (paddr == `MPC_OFS_POLICY);
   wire        wr_stat = wr_done & (paddr == `MPC_OFS_STATUS);
   wire        wr_mask = wr_done & (paddr == `MPC_OFS_MASK);
   wire        wr_rel  = wr_done & (paddr == `MPC_OFS_STATE) & wd[0];
   wire        wr_cmpv = wr_done & (paddr == `MPC_OFS_CMPVAL);
   wire        wr_flag = wr_done & (paddr == `MPC_OFS_FLAGS);

   // ----------------------------------------
   // Enabled trigger sources
   // ----------------------------------------
   wire en_cl  = protection_enable_control[`MPC_EN_CL];
   wire en_oc  = protection_enable_control[`MPC_EN_OC];
   wire en_cmp = protection_enable_control[`MPC_EN_CMP];
   wire en_ovf = protection_enable_control[`MPC_EN_OVF];
   wire sw_src = protection_enable_control[`MPC_EN_SWE] &
                 protection_enable_control[`MPC_EN_SWD];
   wire pol_cl  = protection_policy_select[`MPC_POL_CL];
   wire pol_cmp = protection_policy_select[`MPC_POL_CMP];
   wire pol_sw  = protection_policy_select[`MPC_POL_SW];

   wire trig_cl  = en_cl & current_limit_event;
   wire trig_oc  = en_oc & overcurrent_event;
   wire trig_cmp = en_cmp & stall_compare_event;
   wire trig_ovf = en_ovf & stall_overflow_event;

   // Fault-policy terms act on the live source
   wire fault_cmp = trig_cmp & ~pol_cmp;
   wire fault_sw  = sw_src & ~pol_sw;
   // Pause-policy terms set a latch that only a release write clears
   wire set_cmp   = trig_cmp & pol_cmp;
   wire set_sw    = sw_src & pol_sw;

   // ----------------------------------------
   // Per-source protection requests
   // ----------------------------------------
   // Live set terms join the latches, so protection starts one edge after
   // a source is seen instead of waiting for its latch
   wire hold_cl  = cl_hold | trig_cl;
   wire hold_oc  = oc_latch | trig_oc;
   wire hold_cmp = cmp_latch | fault_cmp | set_cmp;
   wire hold_ovf = ovf_latch | trig_ovf;
   wire hold_sw  = sw_latch | fault_sw | set_sw;
   wire any_hold = hold_cl | hold_oc | hold_cmp | hold_ovf | hold_sw;

   // ----------------------------------------
   // Capture timer and stall events
   // ----------------------------------------
   wire [2:0] hall_now  = {hall_input_c, hall_input_b, hall_input_a};
   // First sample after reset only primes the history, it is not an edge
   wire       hall_edge = hall_valid & |(hall_now ^ hall_prev);
   wire       at_max    = &capture_timer;
   wire [TIMER_W-1:0] timer_inc = capture_timer + {{(TIMER_W-1){1'b0}}, 1'b1};

   always @(posedge mclk) begin
      if (!rst_n) begin
         hall_prev            <= 3'h0;
         hall_valid           <= 1'b0;
         capture_timer        <= {TIMER_W{1'b0}};
         capture_latch        <= {TIMER_W{1'b0}};
         stall_compare_event  <= 1'b0;
         stall_overflow_event <= 1'b0;
      end else begin
         hall_prev <= hall_now;
         hall_valid <= 1'b1;
         // Timer measures time between Hall transitions
         if (hall_edge) begin
            capture_latch <= capture_timer;
            capture_timer <= {TIMER_W{1'b0}};
         end else if (!at_max) begin
            capture_timer <= timer_inc;
         end
         // Slow rotor: step time passes compare value
         stall_compare_event  <= ~hall_edge & (timer_inc == capture_compare) & ~at_max;
         // Saturation fires once; rotor stopped
         stall_overflow_event <= ~hall_edge & (&timer_inc) & ~at_max;
      end
   end

   // ----------------------------------------
   // Protection holds
   // ----------------------------------------
   always @(posedge mclk) begin
      if (!rst_n) begin
         cl_hold   <= 1'b0;
         oc_latch  <= 1'b0;
         cmp_latch <= 1'b0;
         ovf_latch <= 1'b0;
         sw_latch  <= 1'b0;
      end else begin
         // Current limit: hold after flag drops until allowed to resume
         if (trig_cl)
            cl_hold <= 1'b1;
         else if (!pol_cl | pwm_period_start)
            cl_hold <= 1'b0;
         // Overcurrent always latches; undefined policy zero treated as pause
         if (trig_oc)
            oc_latch <= 1'b1;
         else if (wr_rel)
            oc_latch <= 1'b0;
         // Set wins over software release for every latch
         if (set_cmp)
            cmp_latch <= 1'b1;
         else if (wr_rel)
            cmp_latch <= 1'b0;
         // Overflow policy zero is undefined; pause is used either way
         if (trig_ovf)
            ovf_latch <= 1'b1;
         else if (wr_rel)
            ovf_latch <= 1'b0;
         if (set_sw)
            sw_latch <= 1'b1;
         else if (wr_rel)
            sw_latch <= 1'b0;
      end
   end

   // ----------------------------------------
   // Gate drive outputs
   // ----------------------------------------
   always @(posedge mclk) begin
      if (!rst_n) begin
         gate_out       <= 6'h00;
         protect_active <= 1'b0;
      end else begin
         protect_active <= any_hold;
         if (!any_hold)
            gate_out <= pwm_gate_in;
         else if (free_run_select)
            gate_out <= 6'h00;
         else
            gate_out <= `MPC_BRAKE_PAT;
      end
   end

   // ----------------------------------------
   // Sticky status and interrupt
   // ----------------------------------------
   // Events: b4 protection entry, b3 overflow, b2 compare, b1 overcurrent, b0 limit
   wire [4:0] ev_set = {any_hold & ~protect_active,
                        trig_ovf,
                        trig_cmp,
                        trig_oc,
                        trig_cl};
   wire [4:0] clr    = wr_stat ? wd[4:0] : 5'h00;
   wire [4:0] next_status = ev_set | (status & ~clr);

   always @(posedge mclk) begin
      if (!rst_n) begin
         status <= 5'h00;
         irq    <= 1'b0;
      end else begin
         status <= next_status;
         irq    <= |(next_status & mask);
      end
   end

   // ----------------------------------------
   // Register writes
   // ----------------------------------------
   always @(posedge mclk) begin
      if (!rst_n) begin
         protection_enable_control <= `MPC_RST_ENABLE;
         protection_policy_select  <= `MPC_RST_POLICY;
         mask                      <= 5'h00;
         free_run_select           <= 1'b0;
         capture_compare           <= `MPC_RST_CMPVAL;
      end else begin
         if (wr_en)
            protection_enable_control <= wd[7:0] & `MPC_EN_MASK;
         if (wr_pol)
            protection_policy_select <= wd[7:0] & `MPC_POL_MASK;
         if (wr_mask)
            mask <= wd[4:0];
         if (wr_flag)
            free_run_select <= wd[0];
         if (wr_cmpv)
            capture_compare <= wd[TIMER_W-1:0];
      end
   end

   // ----------------------------------------
   // Read path, one wait state
   // ----------------------------------------
   reg [31:0] rd_mux;
   reg        rd_err;

   // State word read back; bit 0 reads zero because release is write-only
   wire [6:0] state_word = {protect_active,
                            sw_latch,
                            ovf_latch,
                            cmp_latch,
                            oc_latch,
                            cl_hold,
                            1'b0};

   always @* begin
      rd_mux = 32'h0000_0000;
      rd_err = 1'b0;
      case (paddr)
         `MPC_OFS_ENABLE:  rd_mux[7:0] = protection_enable_control;
         `MPC_OFS_POLICY:  rd_mux[7:0] = protection_policy_select;
         `MPC_OFS_STATUS:  rd_mux[4:0] = status;
         `MPC_OFS_MASK:    rd_mux[4:0] = mask;
         `MPC_OFS_STATE:   rd_mux[6:0] = state_word;
         `MPC_OFS_CMPVAL:  rd_mux[TIMER_W-1:0] = capture_compare;
         `MPC_OFS_FLAGS:   rd_mux[0] = free_run_select;
         `MPC_OFS_CAPTURE: rd_mux[TIMER_W-1:0] = capture_latch;
         default:          rd_err = 1'b1;
      endcase
   end

   always @(posedge mclk) begin
      if (!rst_n) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= acc;
         // Unmapped addresses answer with the error flag; reads of them also return zero data
         pslverr <= acc & rd_err;
         if (acc & !pwrite)
            prdata <= rd_mux;
      end
   end

endmodule

// ===== mpc_bridge_model.sv
// Model of the three gate-drive transistor pairs of the bridge
`timescale 1ns/1ns
module mpc_bridge_model (
   // Gate drive {AT,AB,BT,BB,CT,CB}
   input  wire logic [5:0] gate,
   // Sticky: a top and bottom switch of one leg were on together
   output logic            shoot_through
);
   initial shoot_through = 1'b0;
   // A real leg shorts the supply; latched so a one-cycle glitch is not lost
   always @(gate)
      if ((gate[5] & gate[4]) | (gate[3] & gate[2]) | (gate[1] & gate[0]))
         shoot_through = 1'b1;
endmodule

// ===== mpc_properties.sv
// Port checks of the motor protection controller
`timescale 1ns/1ns
module mpc_properties (
   // Clock, reset and bus
   input wire logic        mclk, rst_n, psel, penable, pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata, prdata,
   input wire logic        pready, pslverr,
   // Sources and drive
   input wire logic        current_limit_event, overcurrent_event, protect_active,
   input wire logic [5:0]  pwm_gate_in, gate_out
);
   logic [7:0] en;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // Shadow of the enable register, kept from completed bus writes
   always_ff @(posedge mclk)
      if (!rst_n) en <= 8'h00;
      else if (psel && penable && pready && pwrite && paddr == 8'h00) en <= pwdata[7:0];
   brake_or_off_a: assert property (protect_active |-> gate_out == 6'h15 || gate_out == 6'h00)
      else $error("gate pattern wrong while protecting");
   pass_through_a: assert property ($past(rst_n) && !protect_active |-> gate_out == $past(pwm_gate_in))
      else $error("gate drive not passed through");
   one_wait_a: assert property (psel && penable && !pready |=> pready)
      else $error("bus answer late");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   err_data_a: assert property (pslverr |-> pready && (pwrite || prdata == 32'h0))
      else $error("error response malformed");
   oc_trip_a: assert property (en[3] && overcurrent_event |=> protect_active)
      else $error("overcurrent did not protect");
   cl_trip_a: assert property (en[2] && current_limit_event |=> protect_active)
      else $error("current limit did not protect");
   sw_trip_a: assert property (en[7] && en[6] |=> protect_active)
      else $error("software trigger did not protect");
   idle_quiet_a: assert property (en == 8'h00 && !protect_active |=> !protect_active)
      else $error("protection without enabled source");
endmodule
bind mpc_top mpc_properties i_mpc_properties (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .current_limit_event(current_limit_event), .overcurrent_event(overcurrent_event),
   .protect_active(protect_active), .pwm_gate_in(pwm_gate_in), .gate_out(gate_out));

// ===== mpc_bench.sv
// Self-checking bench of the motor protection controller
`timescale 1ns/1ns
module mpc_bench;
   logic        mclk, rst_n, psel, penable, pwrite, cl, oc, ha, pps, serr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, rd;
   logic [5:0]  pwm;
   wire  [31:0] prdata;
   wire  [5:0]  gate_out;
   wire         pready, pslverr, prot, irq, shoot;
   int          err_total, checked, i;
   // {enable, 0, oc, cl, expected protect}
   logic [15:0] rows [7] = '{16'h0403, 16'h0002, 16'h0805, 16'h0004, 16'hC001, 16'h4000, 16'h0C07};
   mpc_top i_mpc_top (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .current_limit_event(cl), .overcurrent_event(oc), .hall_input_a(ha), .hall_input_b(1'b0),
      .hall_input_c(1'b1), .pwm_period_start(pps), .pwm_gate_in(pwm), .gate_out(gate_out),
      .protect_active(prot), .irq(irq));
   mpc_bridge_model i_mpc_bridge_model (.gate(gate_out), .shoot_through(shoot));
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
      end while (pready !== 1'b1);
      rd = prdata;
      serr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      tick(1);
   endtask
   task automatic conclude;
      $display("checks=%0d errors=%0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial begin
      #200000;
      err_total++;
      conclude();
   end
   initial begin
      {psel, penable, pwrite, cl, oc, ha, pps, rst_n} = 8'h00;
      paddr = 8'h00;
      pwdata = 32'h0;
      pwm = 6'h24;
      tick(2);
      rst_n <= 1'b1;
      tick(1);
      apb(0, 8'h04, 0);
      chk(rd, 32'h13);
      apb(1, 8'h00, 32'hFF);
      apb(0, 8'h00, 0);
      chk(rd, 32'hFC);
      chk(prot, 1);
      apb(1, 8'h00, 0);
      tick(2);
      chk(prot, 1);
      apb(1, 8'h10, 1);
      tick(2);
      chk(prot, 0);
      apb(0, 8'h40, 0);
      chk(serr, 1);
      chk(rd, 0);
      apb(1, 8'h04, 32'h17);
      for (i = 0; i < 7; i++) begin
         apb(1, 8'h00, rows[i][15:8]);
         oc <= rows[i][2];
         cl <= rows[i][1];
         tick(2);
         chk(prot, rows[i][0]);
         chk(gate_out, rows[i][0] ? 6'h15 : pwm);
         {oc, cl} <= 2'b00;
         apb(1, 8'h00, 0);
         apb(1, 8'h10, 1);
      end
      // Software trigger in fault policy follows the data bit
      apb(1, 8'h04, 32'h07);
      apb(1, 8'h00, 32'hC0);
      tick(2);
      chk(prot, 1);
      apb(1, 8'h00, 32'h40);
      tick(2);
      chk(prot, 0);
      apb(1, 8'h0C, 2);
      apb(1, 8'h00, 8);
      oc <= 1'b1;
      tick(1);
      oc <= 1'b0;
      tick(3);
      chk({prot, irq}, 2'b11);
      apb(1, 8'h0C, 0);
      tick(2);
      chk(irq, 0);
      apb(1, 8'h08, 32'h1F);
      apb(0, 8'h08, 0);
      chk(rd, 0);
      apb(1, 8'h10, 1);
      tick(2);
      chk(prot, 0);
      // Restart after current limit: at once, then only at a period start
      apb(1, 8'h00, 4);
      for (i = 0; i < 2; i++) begin
         apb(1, 8'h04, i ? 32'h1F : 32'h17);
         cl <= 1'b1;
         tick(2);
         cl <= 1'b0;
         tick(3);
         chk(prot, i);
      end
      pps <= 1'b1;
      tick(1);
      pps <= 1'b0;
      tick(2);
      chk(prot, 0);
      // Stall compare in free-run; a Hall edge restarts the timer
      apb(1, 8'h18, 1);
      apb(1, 8'h14, 32'h10);
      apb(1, 8'h00, 32'h10);
      ha <= 1'b1;
      tick(30);
      chk({prot, gate_out}, 7'h40);
      apb(1, 8'h00, 0);
      apb(1, 8'h10, 1);
      tick(2);
      chk({prot, shoot}, 2'b00);
      conclude();
   end
endmodule
